/* File: src/pio_packet_fifo_port.sv */
// programmed-i/o port onto the transmit and receive packet fifos
// assumes csr strobes are one-cycle pulses and the tag table and the
// mac sit outside; reads answer two cycles after the strobe
//
// Summary of operation
// - watermark event when fill changes to equal watermark
// - interrupt request only when mask permits
// - free dword count, 2000h when empty
// - write port access with byte lane 3 enabled pushes fifo unless it is full
// - transmit begins only on start command
// - header length gives exact payload bytes
// - header index selects tag table entry
// - insert flag adds built vlan tag
// - every read port access pops fifo unless it is empty
// - each read returns exactly one dword
// - status word, vlan word, then data
// - receive packet limited to 64K
// - dropped packets only bump drop counter
// - receive length counts deposited bytes
`timescale 1ns/1ns
module pio_packet_fifo_port
  import pio_fifo_pkg::*;
#(
  parameter int TX_DEPTH = int'(TX_FREE_RESET),
  parameter int RX_DEPTH = 16384
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [7:0] csr_addr,
  input  wire logic       csr_wr,
  input  wire logic       csr_rd,
  input  wire logic [3:0] csr_be,
  input  wire logic [31:0] csr_wdata,
  output logic      [31:0] csr_rdata,
  output logic            csr_rvalid,
  input  wire logic       tx_start_command,
  input  wire logic       tx_watermark_mask,
  output logic            tx_watermark_event,
  output logic            tx_irq_req,
  output logic      [3:0] tag_table_index,
  input  wire logic [15:0] tag_table_tci,
  output tx_beat_t        tx_out,
  output logic            tx_out_valid,
  input  wire logic       tx_out_ready,
  input  wire rx_beat_t   rx_in,
  input  wire logic       rx_in_valid,
  output logic            rx_in_ready,
  output logic      [15:0] rx_drop_count
);

  localparam int TAW = $clog2(TX_DEPTH);
  localparam int RAW = $clog2(RX_DEPTH);

  if ((1 << TAW) != TX_DEPTH || TX_DEPTH > 65535) begin : g_tx_chk
    $error("TX_DEPTH must be a power of two below 65536");
  end
  if ((1 << RAW) != RX_DEPTH || RX_DEPTH < 4) begin : g_rx_chk
    $error("RX_DEPTH must be a power of two of at least 4");
  end

  function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  be);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ---------------- csr decode
  wire [5:0] csr_idx  = csr_addr[7:2];
  wire       wr_wm    = csr_wr && csr_idx == CSR_TX_LOW_WATERMARK;
  wire       wr_port  = csr_wr && csr_idx == CSR_TX_FIFO_WRITE_PORT;
  wire       rd_port  = csr_rd && csr_idx == CSR_RX_FIFO_READ_PORT;

  logic [15:0] wm_q;
  logic [5:0]  rd_idx_q;
  logic        rd_pend_q;
  logic [31:0] csr_rdata_q;
  logic        csr_rvalid_q;

  // ---------------- transmit fifo bookkeeping
  logic [31:0]  asm_q;
  logic [TAW:0] tx_wr_q;
  logic [TAW:0] tx_rd_q;
  logic [TAW:0] tx_cnt_q;
  logic [TAW:0] tx_cnt_d;
  logic [31:0]  tx_mem_q;
  logic         tx_event_q;
  logic         tx_irq_q;
  logic [15:0]  tx_pend_q;

  wire [31:0] asm_word = lane_merge(asm_q, csr_wdata, csr_be);
  wire        tx_full  = tx_cnt_q == (TAW + 1)'(TX_DEPTH);
  wire        tx_push  = wr_port && csr_be[3] && !tx_full;
  wire        tx_pop;
  wire [15:0] tx_free  = 16'(TX_DEPTH) - 16'(tx_cnt_q);

  assign tx_cnt_d = tx_cnt_q + (TAW + 1)'(tx_push) - (TAW + 1)'(tx_pop);

  wire [31:0] wm_merged = lane_merge({16'h0000, wm_q}, csr_wdata, csr_be);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wm_q <= TX_WATERMARK_RESET;
    end else if (wr_wm) begin
      wm_q <= wm_merged[15:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      asm_q <= 32'h0000_0000;
    end else if (wr_port) begin
      asm_q <= csr_be[3] ? 32'h0000_0000 : asm_word;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_wr_q  <= '0;
      tx_cnt_q <= '0;
    end else begin
      tx_wr_q  <= tx_wr_q + (TAW + 1)'(tx_push);
      tx_cnt_q <= tx_cnt_d;
    end
  end

  wire wm_hit = (tx_cnt_d != tx_cnt_q) && (16'(tx_cnt_d) == wm_q);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_event_q <= 1'b0;
      tx_irq_q   <= 1'b0;
    end else begin
      tx_event_q <= wm_hit;
      tx_irq_q   <= wm_hit && tx_watermark_mask;
    end
  end

  assign tx_watermark_event = tx_event_q;
  assign tx_irq_req         = tx_irq_q;

  fifo_ram #(
    .WIDTH (32),
    .DEPTH (TX_DEPTH)
  ) u_tx_ram (
    .clk_sys   (clk_sys),
    .wr_en     (tx_push),
    .wr_addr   (tx_wr_q[TAW-1:0]),
    .wr_data   (asm_word),
    .rd_en     (tx_pop),
    .rd_addr   (tx_rd_q[TAW-1:0]),
    .rd_data_q (tx_mem_q)
  );

  // ---------------- transmit engine
  tx_state_t   tx_st_q;
  logic [15:0] tx_rem_q;
  logic        tx_first_q;
  logic        tx_ins_q;
  logic [3:0]  tx_idx_q;
  tx_beat_t    tx_beat;
  logic        skid_in_ready;

  wire tx_go = tx_st_q == TX_IDLE && tx_pend_q != 16'h0000;
  assign tx_pop = tx_st_q == TX_HRD ||
                  (tx_st_q == TX_RD && skid_in_ready);
  wire [15:0] hdr_len = tx_mem_q[HDR_LEN_LSB +: HDR_LEN_W];
  wire        tx_push_beat = tx_st_q == TX_SEND;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_pend_q <= 16'h0000;
    end else begin
      tx_pend_q <= tx_pend_q + 16'(tx_start_command) - 16'(tx_go);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_rd_q <= '0;
    end else begin
      tx_rd_q <= tx_rd_q + (TAW + 1)'(tx_pop);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_st_q    <= TX_IDLE;
      tx_rem_q   <= 16'h0000;
      tx_first_q <= 1'b0;
      tx_ins_q   <= 1'b0;
      tx_idx_q   <= 4'h0;
    end else begin
      case (tx_st_q)
        TX_IDLE: begin
          if (tx_go) begin
            tx_st_q <= TX_HRD;
          end
        end
        TX_HRD: tx_st_q <= TX_HCAP;
        TX_HCAP: begin
          tx_rem_q   <= hdr_len;
          tx_idx_q   <= tx_mem_q[HDR_IDX_LSB +: HDR_IDX_W];
          tx_ins_q   <= tx_mem_q[HDR_INS_BIT];
          tx_first_q <= 1'b1;
          tx_st_q    <= (hdr_len == 16'h0000) ? TX_IDLE : TX_RD;
        end
        TX_RD: begin
          if (skid_in_ready) begin
            tx_st_q <= TX_SEND;
          end
        end
        TX_SEND: begin
          tx_first_q <= 1'b0;
          tx_rem_q   <= (tx_rem_q > 16'h0004) ? tx_rem_q - 16'h0004
                                              : 16'h0000;
          tx_st_q    <= (tx_rem_q > 16'h0004) ? TX_RD : TX_IDLE;
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  assign tag_table_index = tx_idx_q;

  always_comb begin
    tx_beat            = '0;
    tx_beat.data       = tx_mem_q;
    tx_beat.nbytes     = (tx_rem_q > 16'h0004) ? 3'd4 : tx_rem_q[2:0];
    tx_beat.first      = tx_first_q;
    tx_beat.last       = tx_rem_q <= 16'h0004;
    tx_beat.tag_insert = tx_ins_q && tx_first_q;
    tx_beat.tag_header = tx_ins_q ? {VLAN_TPID, tag_table_tci}
                                  : 32'h0000_0000;
  end

  skid_buf2 #(
    .WIDTH ($bits(tx_beat_t))
  ) u_tx_skid (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_data   (tx_beat),
    .in_valid  (tx_push_beat),
    .in_ready  (skid_in_ready),
    .out_data  (tx_out),
    .out_valid (tx_out_valid),
    .out_ready (tx_out_ready)
  );

  // ---------------- receive fifo
  rx_state_t    rx_st_q;
  logic [RAW:0] rx_base_q;
  logic [RAW:0] rx_cur_q;
  logic [RAW:0] rx_rd_q;
  logic [16:0]  rx_bytes_q;
  logic         rx_drop_q;
  logic [15:0]  rx_stat_q;
  logic [31:0]  rx_vlan_q;
  logic [15:0]  drop_cnt_q;
  logic [31:0]  rx_mem_q;

  assign rx_in_ready = rx_st_q == RX_DATA;

  wire          rx_take   = rx_in_valid && rx_in_ready;
  wire [RAW:0]  rx_used   = rx_cur_q - rx_rd_q;
  wire [16:0]   rx_bytes_n = rx_bytes_q + 17'(rx_in.nbytes);
  wire          rx_oversz = rx_bytes_n > RX_MAX_BYTES - RX_HDR_BYTES;
  wire          rx_full   = rx_used >= (RAW + 1)'(RX_DEPTH);
  wire          rx_bad    = rx_drop_q || rx_oversz || rx_full;
  wire          rx_dwr    = rx_take && !rx_bad;
  wire          rx_empty  = rx_rd_q == rx_base_q;
  wire          rx_pop    = rd_port && !rx_empty;

  logic         rx_we;
  logic [RAW:0] rx_waddr;
  logic [31:0]  rx_wdata;

  always_comb begin
    rx_we    = rx_dwr;
    rx_waddr = rx_cur_q;
    rx_wdata = rx_in.data;
    case (rx_st_q)
      RX_HDR: begin
        rx_we    = 1'b1;
        rx_waddr = rx_base_q;
        rx_wdata = {rx_stat_q, rx_bytes_q[15:0]};
      end
      RX_VLAN: begin
        rx_we    = 1'b1;
        rx_waddr = rx_base_q + (RAW + 1)'(1);
        rx_wdata = rx_vlan_q;
      end
      default: ;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_st_q    <= RX_DATA;
      rx_base_q  <= '0;
      rx_cur_q   <= (RAW + 1)'(2);
      rx_bytes_q <= 17'h00000;
      rx_drop_q  <= 1'b0;
      rx_stat_q  <= 16'h0000;
      rx_vlan_q  <= 32'h0000_0000;
      drop_cnt_q <= 16'h0000;
    end else begin
      case (rx_st_q)
        RX_DATA: begin
          if (rx_take) begin
            rx_cur_q   <= rx_cur_q + (RAW + 1)'(rx_dwr);
            rx_bytes_q <= rx_dwr ? rx_bytes_n : rx_bytes_q;
            rx_drop_q  <= rx_bad;
            if (rx_in.last) begin
              rx_stat_q <= rx_in.status;
              rx_vlan_q <= rx_in.vlan;
              rx_drop_q <= 1'b0;
              if (rx_bad) begin
                drop_cnt_q <= drop_cnt_q + 16'h0001;
                rx_cur_q   <= rx_base_q + (RAW + 1)'(2);
                rx_bytes_q <= 17'h00000;
              end else begin
                rx_st_q <= RX_HDR;
              end
            end
          end
        end
        RX_HDR: rx_st_q <= RX_VLAN;
        RX_VLAN: begin
          rx_st_q    <= RX_DATA;
          rx_base_q  <= rx_cur_q;
          rx_cur_q   <= rx_cur_q + (RAW + 1)'(2);
          rx_bytes_q <= 17'h00000;
        end
        default: rx_st_q <= RX_DATA;
      endcase
    end
  end

  assign rx_drop_count = drop_cnt_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_rd_q <= '0;
    end else begin
      rx_rd_q <= rx_rd_q + (RAW + 1)'(rx_pop);
    end
  end

  fifo_ram #(
    .WIDTH (32),
    .DEPTH (RX_DEPTH)
  ) u_rx_ram (
    .clk_sys   (clk_sys),
    .wr_en     (rx_we),
    .wr_addr   (rx_waddr[RAW-1:0]),
    .wr_data   (rx_wdata),
    .rd_en     (rd_port),
    .rd_addr   (rx_rd_q[RAW-1:0]),
    .rd_data_q (rx_mem_q)
  );

  // ---------------- read answer
  logic [31:0] rd_mux;

  always_comb begin
    case (rd_idx_q)
      CSR_TX_LOW_WATERMARK:  rd_mux = {16'h0000, wm_q};
      CSR_TX_FREE_DWORDS:    rd_mux = {16'h0000, tx_free};
      CSR_RX_FIFO_READ_PORT: rd_mux = rx_mem_q;
      default:               rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_idx_q     <= 6'h00;
      rd_pend_q    <= 1'b0;
      csr_rdata_q  <= 32'h0000_0000;
      csr_rvalid_q <= 1'b0;
    end else begin
      rd_idx_q     <= csr_idx;
      rd_pend_q    <= csr_rd;
      csr_rvalid_q <= rd_pend_q;
      if (rd_pend_q) begin
        csr_rdata_q <= rd_mux;
      end
    end
  end

  assign csr_rdata  = csr_rdata_q;
  assign csr_rvalid = csr_rvalid_q;

endmodule // pio_packet_fifo_port

/* File: src/pio_fifo_pkg.sv */
// constants, field layouts and beat types of the programmed-i/o fifo port
// assumes byte address = 4 * register index on the device csr port
package pio_fifo_pkg;

  // register indices
  localparam logic [5:0] CSR_TX_LOW_WATERMARK   = 6'h14;
  localparam logic [5:0] CSR_TX_FREE_DWORDS     = 6'h15;
  localparam logic [5:0] CSR_TX_FIFO_WRITE_PORT = 6'h16;
  localparam logic [5:0] CSR_RESERVED_SLOT_23   = 6'h17;
  localparam logic [5:0] CSR_RX_FIFO_READ_PORT  = 6'h18;

  // reset values
  localparam logic [15:0] TX_WATERMARK_RESET = 16'h1000;
  localparam logic [15:0] TX_FREE_RESET      = 16'h2000;

  // transmit header layout
  localparam int HDR_LEN_LSB   = 0;
  localparam int HDR_LEN_W     = 16;
  localparam int HDR_IDX_LSB   = 24;
  localparam int HDR_IDX_W     = 4;
  localparam int HDR_INS_BIT   = 28;
  // receive header layout
  localparam int RX_STAT_LSB   = 16;

  localparam logic [15:0] VLAN_TPID    = 16'h8100;
  localparam logic [16:0] RX_MAX_BYTES = 17'h10000;
  localparam logic [16:0] RX_HDR_BYTES = 17'h00008;

  typedef struct packed {
    logic [31:0] data;
    logic [2:0]  nbytes;
    logic        first;
    logic        last;
    logic        tag_insert;
    logic [31:0] tag_header;
  } tx_beat_t;

  typedef struct packed {
    logic [31:0] data;
    logic [2:0]  nbytes;
    logic        last;
    logic [15:0] status;
    logic [31:0] vlan;
  } rx_beat_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_HRD  = 3'b001,
    TX_HCAP = 3'b011,
    TX_RD   = 3'b010,
    TX_SEND = 3'b110
  } tx_state_t;

  typedef enum logic [1:0] {
    RX_DATA = 2'b00,
    RX_HDR  = 2'b01,
    RX_VLAN = 2'b11
  } rx_state_t;

endpackage

/* File: src/fifo_ram.sv */
// simple dual-port word memory with registered read data
// assumes one writer and one reader on clk_sys
`timescale 1ns/1ns
module fifo_ram #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8192,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             clk_sys,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             rd_en,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data_q
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rd_en) begin
      rd_data_q <= mem[rd_addr];
    end
  end

endmodule // fifo_ram

/* File: src/skid_buf2.sv */
// two-entry valid/ready buffer; a stall downstream loses no beat
// assumes synchronous active-high reset on clk_sys
`timescale 1ns/1ns
module skid_buf2 #(
  parameter int WIDTH = 32
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  logic [WIDTH-1:0] slot_q [2];
  logic [1:0]       cnt_q;
  logic             head_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != 2'd2);
  assign out_valid = (cnt_q != 2'd0);
  assign out_data  = slot_q[head_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_q  <= 2'd0;
      head_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_q + {1'b0, push} - {1'b0, pop};
      head_q <= head_q ^ pop;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      slot_q[head_q ^ cnt_q[0]] <= in_data;
    end
  end

endmodule // skid_buf2

/* File: sim/pio_port_monitor.sv */
// assertions on the pins of the programmed-i/o fifo port
// assumes it is bound to pio_packet_fifo_port with one clock clk_sys
`timescale 1ns/1ns
module pio_port_monitor
  import pio_fifo_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        csr_rd,
  input wire logic        csr_rvalid,
  input wire logic        tx_start_command,
  input wire logic        tx_watermark_event,
  input wire logic        tx_irq_req,
  input wire tx_beat_t    tx_out,
  input wire logic        tx_out_valid,
  input wire logic        tx_out_ready,
  input wire logic [15:0] rx_drop_count
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [7:0] starts_q;
  logic [7:0] starts_d;
  // starts not yet seen as a first beat
  assign starts_d = starts_q + 8'(tx_start_command)
                  - 8'(tx_out_valid && tx_out_ready && tx_out.first);
  always_ff @(posedge clk_sys) begin
    if (rst)
      starts_q <= 8'h00;
    else
      starts_q <= starts_d;
  end
  read_answer_a: assert property (csr_rd |-> ##2 csr_rvalid)
    else $error("read not answered");
  answer_cause_a: assert property (csr_rvalid |-> $past(csr_rd, 2))
    else $error("answer without read");
  irq_masked_a: assert property (tx_irq_req |-> tx_watermark_event)
    else $error("request without event");
  event_once_a: assert property (tx_watermark_event |=> !tx_watermark_event)
    else $error("event held");
  beat_held_a: assert property (tx_out_valid && !tx_out_ready
    |=> tx_out_valid && $stable(tx_out))
    else $error("beat lost under stall");
  drop_step_a: assert property ($changed(rx_drop_count)
    |-> rx_drop_count == $past(rx_drop_count) + 16'h1)
    else $error("drop count jump");
  tag_first_a: assert property (tx_out_valid && tx_out.tag_insert
    |-> tx_out.first && tx_out.tag_header[31:16] == VLAN_TPID)
    else $error("bad tag header");
  beat_size_a: assert property (tx_out_valid
    |-> tx_out.nbytes inside {[3'h1:3'h4]})
    else $error("bad beat size");
  start_gate_a: assert property (tx_out_valid && tx_out.first
    |-> starts_q != 8'h00)
    else $error("packet without start");
endmodule // pio_port_monitor

bind pio_packet_fifo_port pio_port_monitor u_mon (
  .clk_sys(clk_sys),
  .rst(rst),
  .csr_rd(csr_rd),
  .csr_rvalid(csr_rvalid),
  .tx_start_command(tx_start_command),
  .tx_watermark_event(tx_watermark_event),
  .tx_irq_req(tx_irq_req),
  .tx_out(tx_out),
  .tx_out_valid(tx_out_valid),
  .tx_out_ready(tx_out_ready),
  .rx_drop_count(rx_drop_count)
);

/* File: sim/mac_side_model.sv */
// mac and tag-table side: collects transmit beats, sends receive beats
// assumes the bench drives stall at falling edges
`timescale 1ns/1ns
module mac_side_model
  import pio_fifo_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       stall,
  input  wire logic [3:0] tag_table_index,
  output logic     [15:0] tag_table_tci,
  input  wire tx_beat_t   tx_out,
  input  wire logic       tx_out_valid,
  output logic            tx_out_ready,
  output rx_beat_t        rx_in,
  output logic            rx_in_valid,
  input  wire logic       rx_in_ready
);
  tx_beat_t got[$];
  // table entry derived from its index
  assign tag_table_tci = {12'hA5C, tag_table_index};
  assign tx_out_ready = !stall;
  initial begin
    rx_in = '0;
    rx_in_valid = 1'b0;
  end
  always @(posedge clk_sys)
    if (tx_out_valid && tx_out_ready)
      got.push_back(tx_out);
  task automatic send(input logic [31:0] d, input logic [2:0] n,
                      input logic l, input logic [15:0] s);
    int k;
    @(negedge clk_sys);
    rx_in = '{data:d, nbytes:n, last:l, status:s, vlan:32'h8100_0ABC};
    rx_in_valid = 1'b1;
    #1;
    for (k = 0; k < 100 && rx_in_ready !== 1'b1; k++)
      @(negedge clk_sys);
    @(posedge clk_sys);
  endtask
  task automatic idle();
    @(negedge clk_sys);
    rx_in_valid = 1'b0;
    rx_in.data = ~rx_in.data;
  endtask
endmodule // mac_side_model

/* File: sim/testbench.sv */
// self-checking bench for the programmed-i/o fifo port
// assumes default fifo depths and the mac side model on the far side
`timescale 1ns/1ns
module testbench
  import pio_fifo_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  csr_addr = 8'h00;
  logic        csr_wr = 1'b0;
  logic        csr_rd = 1'b0;
  logic [3:0]  csr_be = 4'h0;
  logic [31:0] csr_wdata = 32'h0;
  logic        tx_start_command = 1'b0;
  logic        tx_watermark_mask = 1'b0;
  logic        stall = 1'b0;
  logic [31:0] csr_rdata, rd;
  logic        csr_rvalid, tx_watermark_event, tx_irq_req;
  logic [3:0]  tag_table_index;
  logic [15:0] tag_table_tci, rx_drop_count;
  tx_beat_t    tx_out;
  rx_beat_t    rx_in;
  logic        tx_out_valid, tx_out_ready, rx_in_valid, rx_in_ready;
  int          bad_count = 0, n_compared = 0, ev_n = 0, irq_n = 0;
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (tx_watermark_event === 1'b1) ev_n++;
    if (tx_irq_req === 1'b1) irq_n++;
  end
  pio_packet_fifo_port DUT (.clk_sys(clk_sys), .rst(rst),
    .csr_addr(csr_addr), .csr_wr(csr_wr), .csr_rd(csr_rd),
    .csr_be(csr_be), .csr_wdata(csr_wdata), .csr_rdata(csr_rdata),
    .csr_rvalid(csr_rvalid), .tx_start_command(tx_start_command),
    .tx_watermark_mask(tx_watermark_mask),
    .tx_watermark_event(tx_watermark_event), .tx_irq_req(tx_irq_req),
    .tag_table_index(tag_table_index), .tag_table_tci(tag_table_tci),
    .tx_out(tx_out), .tx_out_valid(tx_out_valid),
    .tx_out_ready(tx_out_ready), .rx_in(rx_in), .rx_in_valid(rx_in_valid),
    .rx_in_ready(rx_in_ready), .rx_drop_count(rx_drop_count));
  mac_side_model u_mac (.clk_sys(clk_sys), .stall(stall),
    .tag_table_index(tag_table_index), .tag_table_tci(tag_table_tci),
    .tx_out(tx_out), .tx_out_valid(tx_out_valid),
    .tx_out_ready(tx_out_ready), .rx_in(rx_in), .rx_in_valid(rx_in_valid),
    .rx_in_ready(rx_in_ready));
  task automatic tally_and_finish();
    if (bad_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_up(input string what);
    chk(what, 32'h0, 32'h1);
    tally_and_finish();
  endtask
  task automatic csr(input logic w, input logic [7:0] a,
                     input logic [3:0] be, input logic [31:0] d);
    int k;
    @(negedge clk_sys);
    {csr_addr, csr_be, csr_wdata} = {a, be, d};
    {csr_wr, csr_rd} = {w, !w};
    @(negedge clk_sys);
    {csr_wr, csr_rd} = 2'b00;
    for (k = 0; k < 4 && !w && csr_rvalid !== 1'b1; k++)
      @(negedge clk_sys);
    if (k == 4) give_up("read answer");
    rd = csr_rdata;
  endtask
  task automatic start_tx();
    @(negedge clk_sys);
    tx_start_command = 1'b1;
    @(negedge clk_sys);
    tx_start_command = 1'b0;
  endtask
  task automatic t_reset();
    csr(1'b0, 8'h50, 4'hF, 32'h0); chk("watermark", rd, 32'h1000);
    csr(1'b1, 8'h54, 4'hF, 32'h1234);
    csr(1'b0, 8'h54, 4'hF, 32'h0); chk("free", rd, 32'h2000);
    csr(1'b0, 8'h5C, 4'hF, 32'h0); chk("reserved", rd, 32'h0);
    csr(1'b0, 8'h00, 4'hF, 32'h0); chk("unmapped", rd, 32'h0);
  endtask
  task automatic t_tx();
    tx_beat_t b;
    tx_watermark_mask = 1'b1;
    stall = 1'b1;
    csr(1'b1, 8'h50, 4'h3, 32'hFFFF_0002);
    csr(1'b0, 8'h50, 4'hF, 32'h0); chk("watermark", rd, 32'h2);
    csr(1'b1, 8'h58, 4'hF, 32'h1500_0006);
    csr(1'b1, 8'h58, 4'h1, 32'h0000_0011);
    csr(1'b1, 8'h58, 4'h2, 32'h0000_2200);
    csr(1'b1, 8'h58, 4'h4, 32'h0033_0000);
    csr(1'b1, 8'h58, 4'h8, 32'h4400_0000);
    csr(1'b1, 8'h58, 4'h3, 32'h0000_6655);
    csr(1'b1, 8'h58, 4'hC, 32'h8877_0000);
    csr(1'b0, 8'h54, 4'hF, 32'h0); chk("free", rd, 32'h1FFD);
    chk("events", ev_n, 1);
    chk("requests", irq_n, 1);
    chk("held", tx_out_valid, 1'b0);
    tx_watermark_mask = 1'b0;
    start_tx();
    repeat (12) @(negedge clk_sys);
    chk("stalled", tx_out_valid, 1'b1);
    stall = 1'b0;
    repeat (20) @(negedge clk_sys);
    if (u_mac.got.size() != 2) give_up("tx beats");
    b = u_mac.got.pop_front();
    chk("data0", b.data, 32'h4433_2211);
    chk("flags0", {b.nbytes, b.first, b.last, b.tag_insert}, 6'h25);
    chk("tag", b.tag_header, {VLAN_TPID, 12'hA5C, 4'h5});
    b = u_mac.got.pop_front();
    chk("data1", b.data[15:0], 16'h6655);
    chk("flags1", {b.nbytes, b.first, b.last}, 5'h09);
    csr(1'b0, 8'h54, 4'hF, 32'h0); chk("free", rd, 32'h2000);
    chk("events", ev_n, 2);
    chk("requests", irq_n, 1);
  endtask
  task automatic t_full();
    int k;
    csr(1'b1, 8'h58, 4'hF, 32'h0000_7FFC);
    for (k = 0; k < 8191; k++)
      csr(1'b1, 8'h58, 4'hF, 32'(k));
    csr(1'b0, 8'h54, 4'hF, 32'h0); chk("free full", rd, 32'h0);
    start_tx();
    for (k = 0; k < 40000 && u_mac.got.size() < 8191; k++)
      @(negedge clk_sys);
    repeat (10) @(negedge clk_sys);
    chk("beats", u_mac.got.size(), 8191);
    if (u_mac.got.size() != 8191) give_up("tx drain");
    chk("tail", {u_mac.got[8190].last, u_mac.got[8190].data},
        {1'b1, 32'h1FFE});
    csr(1'b0, 8'h54, 4'hF, 32'h0); chk("free", rd, 32'h2000);
  endtask
  task automatic t_rx();
    int k;
    u_mac.send(32'hD4C3_B2A1, 3'h4, 1'b0, 16'h0);
    u_mac.send(32'h0000_F6E5, 3'h2, 1'b1, 16'h4321);
    u_mac.idle();
    repeat (4) @(negedge clk_sys);
    csr(1'b0, 8'h60, 4'h1, 32'h0); chk("rx head", rd, 32'h4321_0006);
    csr(1'b0, 8'h60, 4'h2, 32'h0); chk("rx vlan", rd, 32'h8100_0ABC);
    csr(1'b0, 8'h60, 4'h3, 32'h0); chk("rx d0", rd, 32'hD4C3_B2A1);
    csr(1'b0, 8'h60, 4'hF, 32'h0); chk("rx d1", rd[15:0], 16'hF6E5);
    for (k = 0; k < 16383; k++)
      u_mac.send(32'(k), 3'h4, k == 16382, 16'h0);
    u_mac.idle();
    repeat (3) @(negedge clk_sys);
    chk("drops", rx_drop_count, 16'h1);
    u_mac.send(32'hCAFE_0001, 3'h4, 1'b1, 16'h0055);
    u_mac.idle();
    repeat (4) @(negedge clk_sys);
    csr(1'b0, 8'h60, 4'hF, 32'h0); chk("after drop", rd, 32'h0055_0004);
  endtask
  initial begin
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    t_reset();
    t_tx();
    t_full();
    t_rx();
    tally_and_finish();
  end
endmodule // testbench
